// ===== hdl/prxc_rx_ctrl.sv
// prxc_rx_ctrl: mac-facing receive data upper bits and frame control lines
// assumes receive bytes arrive from the phy core on clk; tx pins from mac
//
// Behaviour
// (RULE1) gmii only: drive receive data bits 4..7, changing with receive clock
// (RULE2) mac holds tx enable high while tx data is presented
// (RULE3) rgmii tx control carries enable and error on both tx clock edges
// (RULE4) mii/gmii: receive valid high while 4 or 8 data bits are valid
// (RULE5) rgmii: merge valid and error on one line, both rx clock edges
// (RULE6) receive error high, with receive clock, on detected receive error
// (RULE7) rgmii: separate receive error output unused, held low
// (RULE8) rgmii: collision and carrier sense outputs unused, held low
// (RULE9) half duplex: collision high when transmit and receive overlap
// (RULE10) mac treats collision as asynchronous to all link clocks
// (RULE11) full duplex: collision output held low
// (RULE12) half duplex: carrier sense high on receive or transmit activity
// (RULE13) 10/100 full duplex: carrier sense only while receiving a packet
// (RULE14) mac ignores carrier sense at gigabit full duplex
// (RULE15) two general pins, output function chosen by a select setting
// (RULE16) receive clock 2.5, 25 or 125 MHz per speed; gigabit here runs at 25 MHz
// (RULE17) mac sources continuous 125 MHz transmit clock in gmii/rgmii; the bench mac model drives 6.25 MHz
// (RULE18) mii: device drives continuous 2.5 or 25 MHz transmit clock
// (RULE19) rgmii control: rise carries flag, fall carries flag xor error
`timescale 1ns/1ps
module prxc_rx_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire prxc_pkg::prxc_mode_t mode,
  input wire prxc_pkg::prxc_speed_t speed,
  input wire logic full_duplex,
  input wire logic [7:0] core_rx_data,
  input wire logic core_rx_valid,
  input wire logic core_rx_error,
  input wire logic link_up,
  input wire logic [7:0] general_pin_function_select,
  input wire logic tx_clk_in,
  input wire logic tx_ctrl_in,
  output logic receive_clock,
  output logic mii_tx_clock,
  output logic receive_data_bit_four,
  output logic receive_data_bit_five,
  output logic receive_data_bit_six,
  output logic receive_data_bit_seven,
  output logic rx_valid_or_ctrl,
  output logic rx_error,
  output logic collision,
  output logic carrier_sense,
  output logic [prxc_pkg::gpio_n-1:0] general_pin,
  output logic tx_active,
  output logic tx_error
);
  ////////////////////////////////////////////////////////////////////////
  // clock generation
  logic [prxc_pkg::div_w-1:0] half_cyc;
  logic rck, rck_rise, rck_fall;

  always_comb begin
    case (speed)
      prxc_pkg::prxc_spd_10:
        half_cyc = prxc_pkg::div_w'(prxc_pkg::half_10_cyc);
      prxc_pkg::prxc_spd_100:
        half_cyc = prxc_pkg::div_w'(prxc_pkg::half_100_cyc);
      default: half_cyc = prxc_pkg::div_w'(prxc_pkg::half_1000_cyc);
    endcase
  end

  // 125 MHz is out of reach at 50 MHz; gigabit falls back to the fastest
  // divider this clock allows, a known limitation of the model
  prxc_clkdiv u_div ( // [RULE16] [RULE18]
    .clk(clk),
    .srst(srst),
    .half_cyc(half_cyc),
    .clk_out(rck),
    .rise(rck_rise),
    .fall(rck_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit side sampling: two flops before use
  logic [1:0] tck_s_q, tck_s_d;
  // one stage more on control: at a detected edge it holds the pin value
  // from just before that edge, the value the mac set up for that edge
  logic [2:0] tctl_s_q, tctl_s_d;
  logic tck_prev_q, tck_prev_d, tx_en_q, tx_en_d, tx_err_q, tx_err_d;
  logic tx_rise, tx_fall, tx_clk_src;

  // gigabit tx clock is mac-sourced, mii tx clock is ours
  assign tx_clk_src = (mode == prxc_pkg::prxc_mode_mii) ? rck : tx_clk_in;

  always_comb begin
    tck_s_d = {tck_s_q[0], tx_clk_src};
    tctl_s_d = {tctl_s_q[1:0], tx_ctrl_in};
    tck_prev_d = tck_s_q[1];
    tx_rise = tck_s_q[1] & ~tck_prev_q;
    tx_fall = ~tck_s_q[1] & tck_prev_q;
    tx_en_d = tx_en_q;
    tx_err_d = tx_err_q;
    if (mode == prxc_pkg::prxc_mode_rgmii) begin
      if (tx_rise) tx_en_d = tctl_s_q[2]; // [RULE3]
      if (tx_fall) tx_err_d = tctl_s_q[2] ^ tx_en_q; // [RULE3] [RULE19]
    end else if (tx_rise) begin
      tx_en_d = tctl_s_q[2]; // [RULE2]
      tx_err_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tck_s_q <= 2'h0;
      tctl_s_q <= 3'h0;
      tck_prev_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_err_q <= 1'b0;
    end else begin
      tck_s_q <= tck_s_d;
      tctl_s_q <= tctl_s_d;
      tck_prev_q <= tck_prev_d;
      tx_en_q <= tx_en_d;
      tx_err_q <= tx_err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive pins
  logic rck_q, rck_d, txck_q, txck_d;
  logic [3:0] hi_q, hi_d;
  logic dv_q, dv_d, er_q, er_d, col_q, col_d, crs_q, crs_d;
  logic [prxc_pkg::gpio_n-1:0] gp_q, gp_d;
  logic is_rgmii;

  assign is_rgmii = (mode == prxc_pkg::prxc_mode_rgmii);

  always_comb begin
    rck_d = rck_rise ? 1'b1 : (rck_fall ? 1'b0 : rck_q);
    txck_d = (mode == prxc_pkg::prxc_mode_mii) ? rck_d : 1'b0; // [RULE18]
    hi_d = hi_q;
    dv_d = dv_q;
    er_d = er_q;
    // outside rgmii, data, valid and error change only with the receive clock's falling edge,
    // so they are stable when the mac samples on the rise
    if (rck_fall) begin
      hi_d = (mode == prxc_pkg::prxc_mode_gmii) ?
        core_rx_data[7:4] : 4'h0; // [RULE1]
      if (is_rgmii) begin
        dv_d = core_rx_valid; // [RULE5] [RULE19]
        er_d = 1'b0; // [RULE7]
      end else begin
        dv_d = core_rx_valid; // [RULE4]
        er_d = core_rx_error; // [RULE6]
      end
    end
    if (rck_rise && is_rgmii) begin
      dv_d = core_rx_valid ^ core_rx_error; // [RULE5] [RULE19]
    end
    // collision and carrier are asynchronous to link clocks; updated on clk
    if (is_rgmii) begin
      col_d = 1'b0; // [RULE8]
      crs_d = 1'b0; // [RULE8]
    end else if (!full_duplex) begin
      col_d = tx_en_q & core_rx_valid; // [RULE9]
      crs_d = tx_en_q | core_rx_valid; // [RULE12]
    end else begin
      col_d = 1'b0; // [RULE11]
      // gigabit full duplex is undefined; receive-only keeps it quiet
      crs_d = core_rx_valid; // [RULE13]
    end
  end

  for (genvar i = 0; i < prxc_pkg::gpio_n; i++) begin : g_gpio
    logic [3:0] sel;
    assign sel = general_pin_function_select[i*4 +: 4];
    always_comb begin
      case (sel) // [RULE15]
        prxc_pkg::gpio_fn_rx_err: gp_d[i] = core_rx_error;
        prxc_pkg::gpio_fn_col: gp_d[i] = col_d;
        prxc_pkg::gpio_fn_crs: gp_d[i] = crs_d;
        prxc_pkg::gpio_fn_rx_dv: gp_d[i] = core_rx_valid;
        prxc_pkg::gpio_fn_high: gp_d[i] = 1'b1;
        prxc_pkg::gpio_fn_link: gp_d[i] = link_up;
        default: gp_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rck_q <= 1'b0;
      txck_q <= 1'b0;
      hi_q <= 4'h0;
      dv_q <= 1'b0;
      er_q <= 1'b0;
      col_q <= 1'b0;
      crs_q <= 1'b0;
      gp_q <= '0;
    end else begin
      rck_q <= rck_d;
      txck_q <= txck_d;
      hi_q <= hi_d;
      dv_q <= dv_d;
      er_q <= er_d;
      col_q <= col_d;
      crs_q <= crs_d;
      gp_q <= gp_d;
    end
  end

  assign receive_clock = rck_q;
  assign mii_tx_clock = txck_q;
  assign receive_data_bit_four = hi_q[0];
  assign receive_data_bit_five = hi_q[1];
  assign receive_data_bit_six = hi_q[2];
  assign receive_data_bit_seven = hi_q[3];
  assign rx_valid_or_ctrl = dv_q;
  assign rx_error = er_q;
  assign collision = col_q;
  assign carrier_sense = crs_q;
  assign general_pin = gp_q;
  assign tx_active = tx_en_q;
  assign tx_error = tx_err_q;
endmodule // prxc_rx_ctrl

// ===== hdl/prxc_pkg.sv
// prxc_pkg: shared constants for the mac-side receive control block
// assumes a 50 MHz system clock; no registers reachable by software
package prxc_pkg;
  // interface modes
  typedef enum logic [1:0] {
    prxc_mode_mii,
    prxc_mode_gmii,
    prxc_mode_rgmii
  } prxc_mode_t;

  // link speeds
  typedef enum logic [1:0] {
    prxc_spd_10,
    prxc_spd_100,
    prxc_spd_1000
  } prxc_speed_t;

  localparam int unsigned clk_mhz = 50;
  // receive / transmit clock rates in kHz (2.5 MHz, 25 MHz, 125 MHz)
  localparam int unsigned rate_10_khz = 2500;
  localparam int unsigned rate_100_khz = 25000;
  localparam int unsigned rate_1000_khz = 125000;
  // half period in system cycles, rounded down, at least one
  localparam int unsigned half_10_cyc =
    (clk_mhz * 1000) / (2 * rate_10_khz);
  localparam int unsigned half_100_cyc =
    ((clk_mhz * 1000) / (2 * rate_100_khz)) > 0 ?
    ((clk_mhz * 1000) / (2 * rate_100_khz)) : 1;
  localparam int unsigned half_1000_cyc = 1;
  localparam int div_w = 4;

  localparam int gpio_n = 2;
  localparam int gpio_sel_w = 4;
  // pin function codes for the two general pins
  localparam logic [3:0] gpio_fn_low = 4'h0;
  localparam logic [3:0] gpio_fn_rx_err = 4'h1;
  localparam logic [3:0] gpio_fn_col = 4'h2;
  localparam logic [3:0] gpio_fn_crs = 4'h3;
  localparam logic [3:0] gpio_fn_rx_dv = 4'h4;
  localparam logic [3:0] gpio_fn_high = 4'h5;
  localparam logic [3:0] gpio_fn_link = 4'h6;
endpackage

// ===== hdl/prxc_clkdiv.sv
// prxc_clkdiv: divides the system clock into a link clock and edge strobes
// assumes half period is given in system cycles and is at least one
`timescale 1ns/1ps
module prxc_clkdiv (
  input wire logic clk,
  input wire logic srst,
  input wire logic [prxc_pkg::div_w-1:0] half_cyc,
  output logic clk_out,
  output logic rise,
  output logic fall
);
  logic [prxc_pkg::div_w-1:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  logic wrap;

  always_comb begin
    wrap = (cnt_q + 4'h1 >= half_cyc);
    cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;
    lvl_d = wrap ? ~lvl_q : lvl_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 4'h0;
      lvl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  // strobes mark the edge the output is about to take
  assign clk_out = lvl_q;
  assign rise = wrap & ~lvl_q;
  assign fall = wrap & lvl_q;
endmodule // prxc_clkdiv

// ===== bench/prxc_mac_model.sv
// prxc_mac_model: mac side of the transmit pins
// assumes the block samples the control line on both clock edges in rgmii
`timescale 1ns/1ps
module prxc_mac_model (
  input wire logic en,
  input wire logic err,
  input wire logic rgmii,
  output logic tx_clk_in,
  output logic tx_ctrl_in
);
  // free running, never parked between frames
  initial tx_clk_in = 1'b0;
  always #80 tx_clk_in = ~tx_clk_in;
  // one process owns the line: the rise-sampled half (enable, held for the
  // frame) is launched at the fall before it, the fall-sampled half
  // (enable xor error) at the rise
  always @(tx_clk_in) tx_ctrl_in <= (tx_clk_in && rgmii) ? en ^ err : en;
  // col and crs never sampled: async, undefined at gigabit
endmodule // prxc_mac_model

// ===== bench/prxc_rx_ctrl_sva.sv
// prxc_rx_ctrl_sva: port checks on the receive control block
// assumes mode, speed and duplex only change while srst is high
`timescale 1ns/1ps
module prxc_rx_ctrl_sva (
  input wire logic clk,
  input wire logic srst,
  input wire prxc_pkg::prxc_mode_t mode,
  input wire prxc_pkg::prxc_speed_t speed,
  input wire logic full_duplex,
  input wire logic core_rx_valid,
  input wire logic [7:0] general_pin_function_select,
  input wire logic receive_clock,
  input wire logic receive_data_bit_four,
  input wire logic receive_data_bit_five,
  input wire logic receive_data_bit_six,
  input wire logic receive_data_bit_seven,
  input wire logic rx_valid_or_ctrl,
  input wire logic rx_error,
  input wire logic collision,
  input wire logic carrier_sense,
  input wire logic [prxc_pkg::gpio_n-1:0] general_pin,
  input wire logic tx_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic rg = mode == prxc_pkg::prxc_mode_rgmii;
  wire logic [3:0] hi = {receive_data_bit_seven, receive_data_bit_six,
    receive_data_bit_five, receive_data_bit_four};
  a_upper_idle: assert property (
    mode != prxc_pkg::prxc_mode_gmii |-> !hi)
    else $error("upper bits driven outside gmii");
  a_rx_on_edge: assert property (
    !$stable({hi, rx_error}) |-> $fell(receive_clock))
    else $error("rx data moved off the clock fall");
  a_dv_on_edge: assert property (
    !rg && !$stable(rx_valid_or_ctrl) |-> $fell(receive_clock))
    else $error("rx valid moved off the clock fall");
  a_rgmii_no_err: assert property (rg |-> !rx_error)
    else $error("rx error driven in rgmii");
  a_rgmii_quiet: assert property (
    rg |-> !collision && !carrier_sense)
    else $error("col or crs driven in rgmii");
  a_full_no_col: assert property (full_duplex |-> !collision)
    else $error("collision in full duplex");
  a_half_col: assert property (!full_duplex && !rg
    |=> collision == $past(tx_active && core_rx_valid))
    else $error("collision not tx and rx");
  a_half_crs: assert property (!full_duplex && !rg
    |=> carrier_sense == $past(tx_active || core_rx_valid))
    else $error("crs not tx or rx");
  a_full_crs: assert property (full_duplex && !rg
    && speed != prxc_pkg::prxc_spd_1000
    |=> carrier_sense == $past(core_rx_valid))
    else $error("crs not rx in full duplex");
  a_gpio_high: assert property (general_pin_function_select[3:0]
    == prxc_pkg::gpio_fn_high |=> general_pin[0])
    else $error("pin0 not high");
  c_col: cover property (collision);
  c_rgmii_dv: cover property (rg && rx_valid_or_ctrl);
  c_gpio: cover property (general_pin == 2'h3);
endmodule // prxc_rx_ctrl_sva
bind prxc_rx_ctrl prxc_rx_ctrl_sva u_sva (.clk, .srst, .mode, .speed,
  .full_duplex, .core_rx_valid, .general_pin_function_select, .receive_clock,
  .receive_data_bit_four, .receive_data_bit_five, .receive_data_bit_six,
  .receive_data_bit_seven, .rx_valid_or_ctrl, .rx_error, .collision,
  .carrier_sense, .general_pin, .tx_active);

// ===== bench/prxc_rx_ctrl_tb_top.sv
// prxc_rx_ctrl_tb_top: directed scenarios for the receive control block
// assumes the mac model on the transmit pins and a 50 MHz clock
`timescale 1ns/1ps
module prxc_rx_ctrl_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  prxc_pkg::prxc_mode_t mode = prxc_pkg::prxc_mode_mii;
  prxc_pkg::prxc_speed_t speed = prxc_pkg::prxc_spd_100;
  logic full_duplex = 1'b1;
  logic [7:0] core_rx_data = 8'h00;
  logic core_rx_valid = 1'b0;
  logic core_rx_error = 1'b0;
  logic link_up = 1'b0;
  logic [7:0] general_pin_function_select = 8'h00;
  logic tx_en = 1'b0;
  logic tx_err = 1'b0;
  logic tx_clk_in, tx_ctrl_in, receive_clock, mii_tx_clock, rx_valid_or_ctrl;
  logic rx_error, collision, carrier_sense, tx_active, tx_error;
  logic d4, d5, d6, d7;
  logic [1:0] general_pin;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  prxc_rx_ctrl dut (.clk, .srst, .mode, .speed, .full_duplex, .core_rx_data,
    .core_rx_valid, .core_rx_error, .link_up, .general_pin_function_select,
    .tx_clk_in, .tx_ctrl_in, .receive_clock, .mii_tx_clock,
    .receive_data_bit_four(d4), .receive_data_bit_five(d5),
    .receive_data_bit_six(d6), .receive_data_bit_seven(d7), .rx_valid_or_ctrl,
    .rx_error, .collision, .carrier_sense, .general_pin, .tx_active, .tx_error);
  prxc_mac_model mac (.en(tx_en), .err(tx_err),
    .rgmii(mode == prxc_pkg::prxc_mode_rgmii), .tx_clk_in, .tx_ctrl_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // whole run is well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // mode and duplex are static, so each change goes through a full reset
  task automatic cfg(input prxc_pkg::prxc_mode_t m,
      input prxc_pkg::prxc_speed_t s, input logic fd);
    @(negedge clk);
    srst = 1'b1;
    mode = m;
    speed = s;
    full_duplex = fd;
    {core_rx_valid, core_rx_error, tx_en, tx_err} = 4'h0;
    wt(12);
    srst = 1'b0;
    wt(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_gmii;
    // gigabit runs on the fastest divider, so timing matches 100 Mb here
    cfg(prxc_pkg::prxc_mode_gmii, prxc_pkg::prxc_spd_1000, 1'b1);
    {core_rx_data, core_rx_valid, core_rx_error} = {8'ha5, 2'h3};
    wt(6);
    chk({d7, d6, d5, d4}, 8'h0a);
    chk(rx_valid_or_ctrl, 8'h01);
    chk(rx_error, 8'h01);
  endtask
  // any 200-cycle window holds a whole number of clock periods
  task automatic s_clk(input prxc_pkg::prxc_speed_t s, input int exp);
    logic pr, pt;
    int nr, nt;
    cfg(prxc_pkg::prxc_mode_mii, s, 1'b1);
    {core_rx_data, core_rx_valid} = {8'hf0, 1'b1};
    {pr, pt, nr, nt} = {receive_clock, mii_tx_clock, 64'h0};
    repeat (200) begin
      wt(1);
      nr += int'(receive_clock && !pr);
      nt += int'(mii_tx_clock && !pt);
      {pr, pt} = {receive_clock, mii_tx_clock};
    end
    chk(8'(nr), 8'(exp));
    chk(8'(nt), 8'(exp));
    chk({d7, d6, d5, d4}, 8'h00);
    chk(rx_valid_or_ctrl, 8'h01);
  endtask
  task automatic s_rgmii;
    cfg(prxc_pkg::prxc_mode_rgmii, prxc_pkg::prxc_spd_100, 1'b0);
    {core_rx_valid, core_rx_error, tx_en, tx_err} = 4'hf;
    wt(40);
    chk(rx_error, 8'h00);
    chk({collision, carrier_sense}, 8'h00);
    chk({tx_active, tx_error}, 8'h03);
    repeat (4) begin
      wt(1);
      chk(rx_valid_or_ctrl, {7'h0, !receive_clock});
    end
  endtask
  task automatic s_duplex;
    cfg(prxc_pkg::prxc_mode_mii, prxc_pkg::prxc_spd_100, 1'b0);
    {tx_en, core_rx_valid} = 2'h3;
    wt(40);
    chk({collision, carrier_sense}, 8'h03);
    core_rx_valid = 1'b0;
    wt(4);
    chk({collision, carrier_sense}, 8'h01);
    cfg(prxc_pkg::prxc_mode_mii, prxc_pkg::prxc_spd_100, 1'b1);
    tx_en = 1'b1;
    wt(40);
    chk({collision, carrier_sense}, 8'h00);
    core_rx_valid = 1'b1;
    wt(4);
    chk({collision, carrier_sense}, 8'h01);
  endtask
  task automatic s_gpio;
    general_pin_function_select = 8'h45;
    wt(3);
    chk(general_pin, 8'h03);
    general_pin_function_select = 8'h50;
    wt(3);
    chk(general_pin, 8'h02);
    general_pin_function_select = 8'h13;
    wt(3);
    chk(general_pin, 8'h01);
    link_up = 1'b1;
    general_pin_function_select = 8'h26;
    wt(3);
    chk(general_pin, 8'h01);
  endtask
  initial begin
    s_gmii();
    s_clk(prxc_pkg::prxc_spd_10, 10);
    s_clk(prxc_pkg::prxc_spd_100, 100);
    s_rgmii();
    s_duplex();
    s_gpio();
    results();
  end
endmodule // prxc_rx_ctrl_tb_top
